// [dspm_pkg.sv]
// shared constants and types of the dsp multiplier block
package dspm_pkg;
    localparam int OP_W = 72;
    localparam int CH_W = 18;
    localparam int L9_W = 9;
    localparam int L18_W = 18;
    localparam int L36_W = 36;
    localparam int PROD_W = 144;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] SEL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;

    typedef enum logic [1:0] {DSPM_M9, DSPM_M18, DSPM_M36} dspm_mode_t;

    // control word, lsb first from mode upward
    typedef struct packed {
        logic toAdder;
        logic shareSign;
        logic fixSignB;
        logic fixSignA;
        logic signDynB;
        logic signDynA;
        logic signReg;
        logic shiftB;
        logic shiftA;
        logic pipeEn;
        logic inRegEn;
        dspm_mode_t mode;
    } dspm_ctrl_t;
    localparam dspm_ctrl_t CTRL_RST = 13'h0000;

    // picks one of four enable and clear lines per register bank
    typedef struct packed {
        logic [1:0] clrSelP;
        logic [1:0] enaSelP;
        logic [1:0] clrSelB;
        logic [1:0] enaSelB;
        logic [1:0] clrSelA;
        logic [1:0] enaSelA;
    } dspm_sel_t;
    localparam dspm_sel_t SEL_RST = 12'h000;

    typedef struct packed {
        logic shiftEffB;
        logic shiftEffA;
        logic bufFull;
        logic outPending;
        logic pipeValid;
        logic inValid;
        logic limB;
        logic limA;
    } dspm_stat_t;

    typedef struct packed {
        logic toAdder;
        logic isSigned;
        dspm_mode_t mode;
        logic [PROD_W-1:0] product;
    } dspm_prod_t;
endpackage

// [dspm_opreg.sv]
// register bank with selectable asynchronous clear and load enable
`timescale 1ns/1ps
`default_nettype none
module dspm_opreg #(
    parameter int W = 1
) (
    // clock and clears
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clr,
    // load
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    always_ff @(posedge clk_sys or negedge resetn or posedge clr) begin
        if (!resetn) begin
            q <= '0;
        end else if (clr) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// [dspm_skid.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dspm_skid #(
    parameter int W = 1
) (
    // clock, reset, freeze
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    logic [W-1:0] e1_q;
    logic vld1_q;
    logic push;
    logic pop;
    assign push = clkEn & inValid & inReady;
    assign pop = clkEn & outValid & outReady;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outValid <= 1'h0;
            vld1_q <= 1'h0;
            inReady <= 1'h1;
        end else if (clkEn) begin
            outValid <= pop ? (vld1_q | push) : (outValid | push);
            vld1_q <= pop ? 1'h0 : (vld1_q | (push & outValid));
            inReady <= pop ? 1'h1 : !(vld1_q | (push & outValid));
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outData <= '0;
            e1_q <= '0;
        end else begin
            if (pop && vld1_q) begin
                outData <= e1_q;
            end else if (push && (!outValid || pop)) begin
                outData <= inData;
            end
            if (push && outValid && !pop) begin
                e1_q <= inData;
            end
        end
    end
endmodule
`default_nettype wire

// [dspm_mult_block.sv]
// configurable multiplier stage with input banks, shift chain and pipeline
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - eight 9-bit, four 18-bit or one 36-bit multiplier
// - mixed fixed signs limit unsigned operand to 35
// - separate dynamic signs limit both to 35
// - dynamic against fixed operand limits one side
// - operand banks pick enable and clear sets
// - parallel load takes data from routing inputs
// - shift mode drives dedicated chain outputs
// - chain may end at any block
// - either operand may stay parallel in chains
// - no shift mode in 36-bit configuration
// - sign high means signed, low unsigned
// - product signed when either operand signed
// - products keep full precision, never truncated
// - sign controls direct or registered once
// - optional pipeline register after the multiplier
// - product may go to the adder stage
// - 36-bit product built from four 18-bit multipliers
module dspm_mult_block (
    // clock, reset, freeze
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    // apb slave
    input wire logic [dspm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dspm_pkg::DATA_W-1:0] pwdata,
    output logic [dspm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // four shared enable and clear sets
    input wire logic [3:0] enaSet,
    input wire logic [3:0] clrSet,
    // dynamic sign controls
    input wire logic signA,
    input wire logic signB,
    // operand stream
    input wire logic opValid,
    output logic opReady,
    input wire logic [dspm_pkg::OP_W-1:0] opA,
    input wire logic [dspm_pkg::OP_W-1:0] opB,
    // shift chain
    input wire logic [dspm_pkg::CH_W-1:0] chain_in_operand_a,
    input wire logic [dspm_pkg::CH_W-1:0] chain_in_operand_b,
    output logic [dspm_pkg::CH_W-1:0] chain_out_operand_a,
    output logic [dspm_pkg::CH_W-1:0] chain_out_operand_b,
    // product stream towards the adder/output stage
    output logic prodValid,
    input wire logic prodReady,
    output dspm_pkg::dspm_prod_t prodData
);
    dspm_pkg::dspm_ctrl_t ctrl_q;
    dspm_pkg::dspm_sel_t sel_q;
    dspm_pkg::dspm_stat_t stat;
    dspm_pkg::dspm_prod_t multOut;
    dspm_pkg::dspm_prod_t pipeQ;
    dspm_pkg::dspm_prod_t pushData;
    logic [dspm_pkg::OP_W-1:0] regA;
    logic [dspm_pkg::OP_W-1:0] regB;
    logic [dspm_pkg::OP_W-1:0] dA;
    logic [dspm_pkg::OP_W-1:0] dB;
    logic [dspm_pkg::OP_W-1:0] mA;
    logic [dspm_pkg::OP_W-1:0] mB;
    logic [dspm_pkg::L36_W-1:0] a36;
    logic [dspm_pkg::L36_W-1:0] b36;
    logic [dspm_pkg::PROD_W-1:0] prodW;
    logic [1:0] sgnQ;
    logic bufInReady;
    logic advance;
    logic is9;
    logic is36;
    logic shiftEffA;
    logic shiftEffB;
    logic enaA;
    logic enaB;
    logic enaP;
    logic clrA;
    logic clrB;
    logic clrP;
    logic ldA;
    logic ldB;
    logic ldS;
    logic dynA;
    logic dynB;
    logic sA;
    logic sB;
    logic limA;
    logic limB;
    logic v1_q;
    logic v2_q;
    logic src1Valid;
    logic pushValid;

    // configuration decode
    assign is9 = (ctrl_q.mode == dspm_pkg::DSPM_M9);
    assign is36 = (ctrl_q.mode == dspm_pkg::DSPM_M36);
    assign shiftEffA = ctrl_q.shiftA & ctrl_q.inRegEn & !is36;
    assign shiftEffB = ctrl_q.shiftB & ctrl_q.inRegEn & !is36;
    assign enaA = enaSet[sel_q.enaSelA];
    assign enaB = enaSet[sel_q.enaSelB];
    assign enaP = enaSet[sel_q.enaSelP];
    assign clrA = clrSet[sel_q.clrSelA];
    assign clrB = clrSet[sel_q.clrSelB];
    assign clrP = clrSet[sel_q.clrSelP];
    assign advance = clkEn & bufInReady;
    assign ldS = advance & opValid & enaA;
    assign ldA = ldS & ctrl_q.inRegEn;
    assign ldB = advance & opValid & enaB & ctrl_q.inRegEn;

    // bank inputs: routing in parallel mode, neighbour chain in shift mode
    always_comb begin
        dA = opA;
        dB = opB;
        if (shiftEffA) begin
            dA = is9 ? {regA[dspm_pkg::OP_W-dspm_pkg::L9_W-1:0], chain_in_operand_a[dspm_pkg::CH_W-1 -: dspm_pkg::L9_W]}
                     : {regA[dspm_pkg::OP_W-dspm_pkg::L18_W-1:0], chain_in_operand_a};
        end
        if (shiftEffB) begin
            dB = is9 ? {regB[dspm_pkg::OP_W-dspm_pkg::L9_W-1:0], chain_in_operand_b[dspm_pkg::CH_W-1 -: dspm_pkg::L9_W]}
                     : {regB[dspm_pkg::OP_W-dspm_pkg::L18_W-1:0], chain_in_operand_b};
        end
    end

    dspm_opreg #(.W(dspm_pkg::OP_W)) bankA (
        .clk_sys(clk_sys), .resetn(resetn), .clr(clrA), .en(ldA), .d(dA), .q(regA)
    );
    dspm_opreg #(.W(dspm_pkg::OP_W)) bankB (
        .clk_sys(clk_sys), .resetn(resetn), .clr(clrB), .en(ldB), .d(dB), .q(regB)
    );
    // sign stage follows bank A controls so it tracks operand latency
    dspm_opreg #(.W(2)) bankS (
        .clk_sys(clk_sys), .resetn(resetn), .clr(clrA), .en(ldS & ctrl_q.signReg), .d({signB, signA}), .q(sgnQ)
    );

    // top lane always sits in the high bits; a 9-bit chain uses the upper nine
    assign chain_out_operand_a = regA[dspm_pkg::OP_W-1 -: dspm_pkg::CH_W];
    assign chain_out_operand_b = regB[dspm_pkg::OP_W-1 -: dspm_pkg::CH_W];

    // sign selection
    assign dynA = ctrl_q.signReg ? sgnQ[0] : signA;
    assign dynB = ctrl_q.shareSign ? dynA : (ctrl_q.signReg ? sgnQ[1] : signB);
    assign sA = ctrl_q.signDynA ? dynA : ctrl_q.fixSignA;
    assign sB = ctrl_q.signDynB ? dynB : ctrl_q.fixSignB;

    // 36-bit operand width limits by sign arrangement
    always_comb begin
        limA = 1'h0;
        limB = 1'h0;
        if (is36) begin
            if (ctrl_q.signDynA && ctrl_q.signDynB) begin
                limA = !ctrl_q.shareSign;
                limB = !ctrl_q.shareSign;
            end else if (!ctrl_q.signDynA && !ctrl_q.signDynB) begin
                limA = !ctrl_q.fixSignA & ctrl_q.fixSignB;
                limB = ctrl_q.fixSignA & !ctrl_q.fixSignB;
            end else if (ctrl_q.signDynA) begin
                limA = ctrl_q.fixSignB;
                limB = !ctrl_q.fixSignB;
            end else begin
                limB = ctrl_q.fixSignA;
                limA = !ctrl_q.fixSignA;
            end
        end
    end

    assign mA = ctrl_q.inRegEn ? regA : opA;
    assign mB = ctrl_q.inRegEn ? regB : opB;
    // a limited operand is 35 bits: bit 35 copies bit 34 if signed, else zero
    assign a36 = limA ? {sA & mA[34], mA[34:0]} : mA[dspm_pkg::L36_W-1:0];
    assign b36 = limB ? {sB & mB[34], mB[34:0]} : mB[dspm_pkg::L36_W-1:0];

    // eight 9-bit lanes, each extended by one sign bit
    logic signed [19:0] pp9 [8];
    for (genvar i = 0; i < 8; i++) begin : g_l9
        assign pp9[i] = $signed({sA & mA[9*i+8], mA[9*i +: 9]}) * $signed({sB & mB[9*i+8], mB[9*i +: 9]});
    end

    // four 18-bit lanes; in 36-bit mode they form the partial products
    logic [17:0] la [4];
    logic [17:0] lb [4];
    logic [3:0] lsa;
    logic [3:0] lsb;
    logic signed [37:0] pp18 [4];
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            la[i] = mA[18*i +: 18];
            lb[i] = mB[18*i +: 18];
        end
        lsa = {4{sA}};
        lsb = {4{sB}};
        if (is36) begin
            la[0] = a36[17:0];
            lb[0] = b36[17:0];
            la[1] = a36[17:0];
            lb[1] = b36[35:18];
            la[2] = a36[35:18];
            lb[2] = b36[17:0];
            la[3] = a36[35:18];
            lb[3] = b36[35:18];
            lsa = {sA, sA, 1'h0, 1'h0};
            lsb = {sB, 1'h0, sB, 1'h0};
        end
    end
    for (genvar i = 0; i < 4; i++) begin : g_l18
        assign pp18[i] = $signed({lsa[i] & la[i][17], la[i]}) * $signed({lsb[i] & lb[i][17], lb[i]});
    end

    // shift-and-add of the four partial products
    logic signed [73:0] sum36;
    assign sum36 = (74'(pp18[3]) <<< 36) + ((74'(pp18[1]) + 74'(pp18[2])) <<< 18) + 74'(pp18[0]);

    // full-width products packed lane by lane
    always_comb begin
        prodW = '0;
        case (ctrl_q.mode)
            dspm_pkg::DSPM_M9: begin
                for (int i = 0; i < 8; i++) begin
                    prodW[18*i +: 18] = pp9[i][17:0];
                end
            end
            dspm_pkg::DSPM_M18: begin
                for (int i = 0; i < 4; i++) begin
                    prodW[36*i +: 36] = pp18[i][35:0];
                end
            end
            dspm_pkg::DSPM_M36: begin
                prodW[71:0] = sum36[71:0];
            end
            default: begin
                prodW = '0;
            end
        endcase
    end

    always_comb begin
        multOut.toAdder = ctrl_q.toAdder;
        multOut.isSigned = sA | sB;
        multOut.mode = ctrl_q.mode;
        multOut.product = prodW;
    end

    dspm_opreg #(.W($bits(dspm_pkg::dspm_prod_t))) pipeReg (
        .clk_sys(clk_sys), .resetn(resetn), .clr(clrP), .en(advance & enaP & ctrl_q.pipeEn), .d(multOut), .q(pipeQ)
    );

    // stage valid tracking; every stage moves only when the buffer has room
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            v1_q <= 1'h0;
            v2_q <= 1'h0;
        end else if (advance) begin
            v1_q <= opValid;
            v2_q <= src1Valid;
        end
    end
    assign src1Valid = ctrl_q.inRegEn ? v1_q : opValid;
    assign pushValid = ctrl_q.pipeEn ? v2_q : src1Valid;
    assign pushData = ctrl_q.pipeEn ? pipeQ : multOut;

    dspm_skid #(.W($bits(dspm_pkg::dspm_prod_t))) outBuf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clkEn(clkEn),
        .inValid(pushValid),
        .inReady(bufInReady),
        .inData(pushData),
        .outValid(prodValid),
        .outReady(prodReady),
        .outData(prodData)
    );
    assign opReady = bufInReady;

    // status view
    always_comb begin
        stat.shiftEffB = shiftEffB;
        stat.shiftEffA = shiftEffA;
        stat.bufFull = !bufInReady;
        stat.outPending = prodValid;
        stat.pipeValid = v2_q;
        stat.inValid = v1_q;
        stat.limB = limB;
        stat.limA = limA;
    end

    // apb slave: one wait state, then pready for one cycle
    logic [dspm_pkg::DATA_W-1:0] rdVal;
    logic hit;
    logic wrOk;
    always_comb begin
        rdVal = '0;
        hit = 1'h1;
        wrOk = 1'h1;
        case (paddr)
            dspm_pkg::CTRL_OFS: rdVal = dspm_pkg::DATA_W'(ctrl_q);
            dspm_pkg::SEL_OFS: rdVal = dspm_pkg::DATA_W'(sel_q);
            dspm_pkg::STAT_OFS: begin
                rdVal = dspm_pkg::DATA_W'(stat);
                wrOk = 1'h0;
            end
            default: begin
                hit = 1'h0;
                wrOk = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'h0;
            pslverr <= 1'h0;
            prdata <= '0;
        end else if (clkEn) begin
            if (psel && penable && !pready) begin
                pready <= 1'h1;
                pslverr <= pwrite ? !wrOk : !hit;
                prdata <= pwrite ? '0 : rdVal;
            end else begin
                pready <= 1'h0;
                pslverr <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= dspm_pkg::CTRL_RST;
            sel_q <= dspm_pkg::SEL_RST;
        end else if (clkEn && psel && penable && pready && pwrite) begin
            if (paddr == dspm_pkg::CTRL_OFS) begin
                ctrl_q <= dspm_pkg::dspm_ctrl_t'(pwdata[$bits(dspm_pkg::dspm_ctrl_t)-1:0]);
            end
            if (paddr == dspm_pkg::SEL_OFS) begin
                sel_q <= dspm_pkg::dspm_sel_t'(pwdata[$bits(dspm_pkg::dspm_sel_t)-1:0]);
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    lane_nine_a: assert property (is9 && !ctrl_q.inRegEn && opA[71:63] == 9'h000
        |-> multOut.product[143:126] == 18'h00000) else $error("9-bit lane 7 not isolated");
    fixed_match_a: assert property (is36 && !ctrl_q.signDynA && !ctrl_q.signDynB
        && ctrl_q.fixSignA == ctrl_q.fixSignB |-> !limA && !limB) else $error("matched signs limited");
    dyn_sep_a: assert property (is36 && ctrl_q.signDynA && ctrl_q.signDynB
        |-> limA == !ctrl_q.shareSign && limB == !ctrl_q.shareSign) else $error("dynamic limit wrong");
    dyn_fixed_a: assert property (is36 && ctrl_q.signDynA && !ctrl_q.signDynB
        |-> limA == ctrl_q.fixSignB && limB == !ctrl_q.fixSignB) else $error("mixed limit wrong");
    par_load_a: assert property (ldA && !shiftEffA && !clrA
        |=> regA == $past(opA) || clrA) else $error("parallel load lost");
    chain_step_a: assert property (ldA && shiftEffA && !is9 && !clrA
        |=> chain_out_operand_a == $past(regA[53:36]) || clrA) else $error("chain step wrong");
    no_shift36_a: assert property (is36 |-> !shiftEffA && !shiftEffB) else $error("shift in 36 mode");
    unsigned_prod_a: assert property (!ctrl_q.signDynA && !ctrl_q.signDynB && !ctrl_q.fixSignA
        && !ctrl_q.fixSignB |-> !multOut.isSigned) else $error("unsigned product flagged");
    full_prec_a: assert property (ctrl_q.mode == dspm_pkg::DSPM_M18 && !ctrl_q.inRegEn && sA && sB
        && opA[17:0] == 18'h3FFFF && opB[17:0] == 18'h3FFFF
        |-> multOut.product[35:0] == 36'h000000001) else $error("signed lane product wrong");
    big_split_a: assert property (is36 && !ctrl_q.inRegEn && !limA && !limB
        && opA[35:0] == 36'h000040000 && opB[35:0] == 36'h000040000
        |-> multOut.product[71:0] == 72'h001000000000) else $error("36-bit split wrong");
    sign_reg_a: assert property (ctrl_q.signReg && ldS && !clrA
        |=> sgnQ == $past({signB, signA}) || clrA) else $error("sign stage lost");
    pipe_lat_a: assert property (advance && enaP && ctrl_q.pipeEn && !clrP
        |=> pipeQ == $past(multOut) || clrP) else $error("pipeline stage lost");
    clear_zero_a: assert property (clrA |-> regA == '0) else $error("bank A not cleared");
    hold_bank_a: assert property (!ldA && !clrA |=> $stable(regA) || clrA) else $error("bank A moved");

    shift_run_c: cover property (ldA && shiftEffA ##1 ldA && shiftEffA);
    big_mult_c: cover property (is36 && pushValid && bufInReady);
    stall_c: cover property (!bufInReady && prodValid && !prodReady);
endmodule
`default_nettype wire

// [dspm_sink.sv]
// downstream stage model that takes products and can stall
`timescale 1ns/1ps
`default_nettype none
module dspm_sink (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // product stream
    input wire logic prodValid,
    output logic prodReady,
    input wire dspm_pkg::dspm_prod_t prodData,
    // bench control
    input wire logic stall
);
    dspm_pkg::dspm_prod_t got[$];
    assign prodReady = !stall;
    always @(posedge clk_sys) begin
        if (resetn && prodValid && prodReady) begin
            got.push_back(prodData);
        end
    end
endmodule
`default_nettype wire

// [dspm_mult_block_test.sv]
// self-checking bench for the dsp multiplier block
`timescale 1ns/1ps
`default_nettype none
module dspm_mult_block_test;
    localparam logic [71:0] P = 72'hFF1234_5678_9ABC_DEF0;
    localparam logic [71:0] Q = 72'h80_1357_9BDF_0246_8ACE;
    localparam logic [71:0] XA = 72'h8_0000_0003;
    localparam logic [71:0] XB = 72'hF_FFFF_FFFD;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, signA, signB, perr;
    logic opValid, opReady, prodValid, prodReady, stall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] enaSet, clrSet;
    logic [71:0] opA, opB;
    logic [17:0] chA, chB, coA, coB;
    dspm_pkg::dspm_prod_t prodData;
    int err_count = 0;
    int n_checks = 0;
    int n;

    dspm_mult_block dspm_mult_block_i (.clk_sys(clk_sys), .resetn(resetn), .clkEn(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enaSet(enaSet), .clrSet(clrSet), .signA(signA), .signB(signB), .opValid(opValid),
        .opReady(opReady), .opA(opA), .opB(opB), .chain_in_operand_a(chA), .chain_in_operand_b(chB),
        .chain_out_operand_a(coA), .chain_out_operand_b(coB), .prodValid(prodValid), .prodReady(prodReady),
        .prodData(prodData));
    dspm_sink dspm_sink_i (.clk_sys(clk_sys), .resetn(resetn), .prodValid(prodValid), .prodReady(prodReady),
        .prodData(prodData), .stall(stall));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // lane products with sign extension and optional bit 35 limit
    function automatic logic [143:0] exp_prod(int w, logic [71:0] a, logic [71:0] b, logic sa, logic sb,
                                              logic la, logic lb);
        logic [143:0] r;
        logic [143:0] p;
        logic signed [72:0] x;
        logic signed [72:0] y;
        r = '0;
        for (int i = 0; i < ((w == 36) ? 1 : 72 / w); i++) begin
            x = '0;
            y = '0;
            for (int k = 0; k < w; k++) begin
                x[k] = a[i * w + k];
                y[k] = b[i * w + k];
            end
            if (la) x[35] = sa & x[34];
            if (lb) y[35] = sb & y[34];
            for (int k = w; k < 73; k++) begin
                x[k] = sa & x[w - 1];
                y[k] = sb & y[w - 1];
            end
            p = x * y;
            for (int k = 0; k < 2 * w; k++) r[i * 2 * w + k] = p[k];
        end
        return r;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // one idle edge so a following call never re-drives psel in the same step
        @(posedge clk_sys);
    endtask

    task automatic send(input logic [71:0] a, input logic [71:0] b);
        opValid <= 1'b1;
        opA <= a;
        opB <= b;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (opReady !== 1'h1);
    endtask

    task automatic take(input dspm_pkg::dspm_prod_t exp);
        n = 0;
        while (dspm_sink_i.got.size() == 0 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (dspm_sink_i.got.size() == 0) chk(0, 1);
        else chk(dspm_sink_i.got.pop_front(), exp);
        @(posedge clk_sys);
    endtask

    // effective signs sa and sb drive the pins as well
    task automatic tcase(input logic [12:0] c, input logic sa, input logic sb, input int w, input logic la,
                         input logic lb, input logic [71:0] a, input logic [71:0] b);
        apb(1'b1, dspm_pkg::CTRL_OFS, {19'h0, c});
        signA <= sa;
        signB <= sb;
        send(a, b);
        opValid <= 1'b0;
        take({c[12], sa | sb, c[1:0], exp_prod(w, a, b, sa, sb, la, lb)});
    endtask

    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, signA, signB, opValid, opA, opB, chA, chB} = '0;
        enaSet = 4'hF;
        clrSet = 4'h0;
        stall = 1'b0;
        repeat (10) @(posedge clk_sys);
        chk({opReady, prodValid, coA}, {1'b1, 1'b0, 18'h0});
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, dspm_pkg::CTRL_OFS, 32'h0);
        chk({perr, rdat}, 33'h0);
        apb(1'b1, dspm_pkg::STAT_OFS, 32'hFF);
        chk(perr, 1'b1);
        apb(1'b0, 8'h0C, 32'h0);
        chk({perr, rdat}, {1'b1, 32'h0});
        tcase(13'h0000, 0, 0, 9, 0, 0, P, Q);
        tcase(13'h0181, 1, 0, 18, 0, 0, P, Q);
        tcase(13'h0181, 0, 0, 18, 0, 0, P, Q);
        tcase(13'h0602, 1, 1, 36, 0, 0, XA, XB);
        tcase(13'h0202, 1, 0, 36, 0, 1, XA, XB);
        tcase(13'h0182, 1, 1, 36, 1, 1, XA, XB);
        tcase(13'h0982, 1, 1, 36, 0, 0, XA, XB);
        tcase(13'h0082, 1, 0, 36, 0, 1, XA, XB);
        tcase(13'h0482, 1, 1, 36, 1, 0, XA, XB);
        tcase(13'h1000, 0, 0, 9, 0, 0, P, Q);
        tcase(13'h0016, 0, 0, 36, 0, 0, XA, XB);
        tcase(13'h0181, 1, 1, 18, 0, 0, {4{18'h3FFFF}}, {4{18'h3FFFF}});
        tcase(13'h0002, 0, 0, 36, 0, 0, 72'h4_0000, 72'h4_0000);
        // registered sign: pin drops right after the load, product keeps the captured sign
        apb(1'h1, dspm_pkg::CTRL_OFS, 32'h1C5);
        signA <= 1'h1;
        send(P, Q);
        signA <= 1'h0;
        opValid <= 1'h0;
        take({4'h5, exp_prod(18, P, Q, 1'h1, 1'h0, 1'h0, 1'h0)});
        apb(1'b1, dspm_pkg::SEL_OFS, 32'h0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, dspm_pkg::CTRL_OFS, k ? 32'hD : 32'h1);
            send(P, Q);
            opValid <= 1'b0;
            // n counts edges from the taking edge, that edge included
            n = 1;
            #1;
            while (prodValid !== 1'h1 && n < 9) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk(n, k ? 3 : 1);
            repeat (2) @(posedge clk_sys);
            dspm_sink_i.got.delete();
        end
        apb(1'b1, dspm_pkg::SEL_OFS, 32'h1);
        apb(1'b1, dspm_pkg::CTRL_OFS, 32'h5);
        send(P, Q);
        opValid <= 1'b0;
        take({4'h1, exp_prod(18, P, Q, 0, 0, 0, 0)});
        enaSet <= 4'b1101;
        send(~P, Q);
        opValid <= 1'b0;
        take({4'h1, exp_prod(18, P, Q, 0, 0, 0, 0)});
        enaSet <= 4'hF;
        apb(1'b1, dspm_pkg::SEL_OFS, 32'h0);
        apb(1'b1, dspm_pkg::CTRL_OFS, 32'h15);
        dspm_sink_i.got.delete();
        for (int k = 1; k < 5; k++) begin
            chA <= 18'(k);
            send(P, {4{18'h3}});
        end
        opValid <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(coA, 18'h1);
        chk(coB, 18'h3);
        chk(dspm_sink_i.got[3], {4'h1, exp_prod(18, {18'h1, 18'h2, 18'h3, 18'h4}, {4{18'h3}}, 0, 0, 0, 0)});
        clrSet <= 4'h1;
        #1;
        chk(coA, 18'h0);
        @(posedge clk_sys);
        clrSet <= 4'h0;
        // 9-bit chain on operand b: eight steps fill all lanes
        apb(1'h1, dspm_pkg::CTRL_OFS, 32'h24);
        for (int k = 1; k < 9; k++) begin
            chB <= {9'(k), 9'h000};
            send(P, Q);
        end
        opValid <= 1'h0;
        @(posedge clk_sys);
        chk(coB, {9'h001, 9'h002});
        apb(1'b1, dspm_pkg::CTRL_OFS, 32'h0);
        dspm_sink_i.got.delete();
        stall <= 1'b1;
        send(P, Q);
        send(Q, P);
        opValid <= 1'b0;
        #1;
        chk(opReady, 1'b0);
        @(posedge clk_sys);
        stall <= 1'b0;
        take({4'h0, exp_prod(9, P, Q, 0, 0, 0, 0)});
        take({4'h0, exp_prod(9, Q, P, 0, 0, 0, 0)});
        close_out();
    end
endmodule
`default_nettype wire
